// File: core/pudc_counter.v
`timescale 1ns/1ps
`include "pudc_map.vh"

module pudc_counter
(
   // clock and reset
   input  wire clk,
   input  wire reset_n,

   // control
   input  wire count_clear,
   input  wire load_enable,
   input  wire count_up,
   input  wire carry_in_n,

   // preset value
   input  wire load_value_bit0,
   input  wire load_value_bit1,
   input  wire load_value_bit2,
   input  wire load_value_bit3,

   // count and terminal flag
   output wire count_bit0,
   output wire count_bit1,
   output wire count_bit2,
   output wire count_bit3,
   output wire carry_out_n
);

   // ==========================================================
   // helpers
   // ==========================================================
   // one step up; four-bit arithmetic wraps fifteen to zero
   function [`PUDC_WIDTH-1:0] inc_count;
      input [`PUDC_WIDTH-1:0] cur;
      begin
         inc_count = cur + `PUDC_STEP;
      end
   endfunction

   // one step down; four-bit arithmetic wraps zero to fifteen
   function [`PUDC_WIDTH-1:0] dec_count;
      input [`PUDC_WIDTH-1:0] cur;
      begin
         dec_count = cur - `PUDC_STEP;
      end
   endfunction

   // direction picks the step; carry-in gating lives in the caller
   function [`PUDC_WIDTH-1:0] step_count;
      input [`PUDC_WIDTH-1:0] cur;
      input                   up;
      begin
         if (up)
         begin
            step_count = inc_count(cur);
         end
         else
         begin
            step_count = dec_count(cur);
         end
      end
   endfunction

   // terminal value depends on direction
   function is_terminal;
      input [`PUDC_WIDTH-1:0] cur;
      input                   up;
      begin
         if (up)
         begin
            is_terminal = (cur == `PUDC_TOP_VAL);
         end
         else
         begin
            is_terminal = (cur == `PUDC_BOTTOM_VAL);
         end
      end
   endfunction

   // clear beats preset, preset beats the fallback value
   function [`PUDC_WIDTH-1:0] override;
      input                   clear;
      input                   load;
      input [`PUDC_WIDTH-1:0] value;
      input [`PUDC_WIDTH-1:0] other;
      begin
         if (clear)
         begin
            override = `PUDC_RESET_VAL;
         end
         else if (load)
         begin
            override = value;
         end
         else
         begin
            override = other;
         end
      end
   endfunction

   // ==========================================================
   // count register
   // ==========================================================
   wire [`PUDC_WIDTH-1:0] load_value;
   wire [`PUDC_WIDTH-1:0] step_value;
   wire                   count_en;
   wire                   hold_en;
   reg  [`PUDC_WIDTH-1:0] count_q;
   reg  [`PUDC_WIDTH-1:0] count_d;
   reg  [`PUDC_WIDTH-1:0] count_out;

   assign load_value = {load_value_bit3, load_value_bit2,
                        load_value_bit1, load_value_bit0};

   // ==========================================================
   // control decode
   // ==========================================================
   // counting needs carry-in low with neither clear nor preset active
   assign count_en   = ~carry_in_n & ~count_clear & ~load_enable;
   assign hold_en    = carry_in_n & ~count_clear & ~load_enable;
   assign step_value = step_count(count_q, count_up);

   // ==========================================================
   // next count
   // ==========================================================
   always @*
   begin
      if (count_en)
      begin
         count_d = step_value;
      end
      else if (hold_en)
      begin
         count_d = count_q;
      end
      else
      begin
         count_d = override(count_clear, load_enable, load_value, count_q);
      end
   end

   // ==========================================================
   // register
   // ==========================================================
   // async reset clears only the register; clear and preset still steer the view
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_q <= `PUDC_RESET_VAL;
      end
      else
      begin
         count_q <= count_d;
      end
   end

   // ==========================================================
   // visible count: clear and preset bypass the clock
   // ==========================================================
   // a preset dropped before any clock edge is never stored:
   // the old count reappears, so hold the preset across one edge
   wire [1:0] view_sel;

   // clear wins over preset, as in the register path
   assign view_sel = {count_clear, load_enable};

   always @*
   begin
      case (view_sel)
         2'b00:
         begin
            count_out = count_q;
         end
         2'b01:
         begin
            count_out = load_value;
         end
         default:
         begin
            count_out = `PUDC_RESET_VAL;
         end
      endcase
   end

   // ==========================================================
   // count outputs, lsb first
   // ==========================================================
   assign count_bit0 = count_out[0];
   assign count_bit1 = count_out[1];
   assign count_bit2 = count_out[2];
   assign count_bit3 = count_out[3];

   // ==========================================================
   // terminal count flag
   // ==========================================================
   // combinational from carry-in so a chain of stages settles in one clock
   wire term_up;
   wire term_down;
   wire term_hit;
   wire carry_en;

   assign term_up     = is_terminal(count_out, 1'b1);
   assign term_down   = is_terminal(count_out, 1'b0);
   assign term_hit    = count_up ? term_up : term_down;
   assign carry_en    = ~carry_in_n;
   assign carry_out_n = ~(carry_en & term_hit);

endmodule

// File: shared/pudc_map.vh
`ifndef PUDC_MAP_VH
`define PUDC_MAP_VH

// count width and its two terminal values
`define PUDC_WIDTH      4
`define PUDC_RESET_VAL  4'h0
`define PUDC_TOP_VAL    4'hf
`define PUDC_BOTTOM_VAL 4'h0
`define PUDC_STEP       4'h1

`endif

// File: tb/pudc_chk_assertions.sv
`timescale 1ns/1ps
module pudc_chk(input wire clk, reset_n, count_clear, load_enable, count_up, carry_in_n,
   load_value_bit0, load_value_bit1, load_value_bit2, load_value_bit3,
   count_bit0, count_bit1, count_bit2, count_bit3, carry_out_n);
   wire [3:0] q = {count_bit3, count_bit2, count_bit1, count_bit0};
   wire [3:0] pv = {load_value_bit3, load_value_bit2, load_value_bit1, load_value_bit0};
   wire run = !count_clear && !load_enable;
   hold_count_a: assert property (@(posedge clk) disable iff (!reset_n)
      run && carry_in_n ##1 run |-> q == $past(q))
      else $error("count moved while held");
   count_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
      run && !carry_in_n && count_up && q == 4'hf ##1 run |-> q == 4'h0)
      else $error("no wrap to zero");
   clear_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      count_clear |-> q == 4'h0)
      else $error("clear did not zero count");
   preset_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      !count_clear && load_enable |-> q == pv)
      else $error("count not following preset");
   carry_up_a: assert property (@(posedge clk) disable iff (!reset_n)
      count_up |-> carry_out_n == !(!carry_in_n && q == 4'hf))
      else $error("bad carry counting up");
   carry_down_a: assert property (@(posedge clk) disable iff (!reset_n)
      !count_up |-> carry_out_n == !(!carry_in_n && q == 4'h0))
      else $error("bad carry counting down");
   count_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      run && !carry_in_n ##1 run |-> q == $past(q) + ($past(count_up) ? 4'h1 : 4'hf))
      else $error("bad step");
endmodule
bind pudc_counter pudc_chk pudc_chk_inst(.*);

// File: tb/pudc_next.sv
`timescale 1ns/1ps
module pudc_next(input wire clk, reset_n, carry_in_n, output reg [3:0] hi_q);
   always @(posedge clk or negedge reset_n)
      if (!reset_n)
         hi_q <= 4'h0;
      else if (!carry_in_n)
         hi_q <= hi_q + 4'h1;
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
   reg clk = 0, reset_n = 0, cl = 0, ld = 0, up = 0, ci = 1;
   reg [3:0] p = 0, m = 0, e, hn = 0;
   reg [4:0] n;
   wire [3:0] hi;
   reg [4:0] x [$];
   integer r, errors = 0, cmp_count = 0;
   wire [4:0] q;
   pudc_counter pudc_counter_inst(.clk(clk), .reset_n(reset_n), .count_clear(cl),
      .load_enable(ld), .count_up(up), .carry_in_n(ci), .load_value_bit0(p[0]),
      .load_value_bit1(p[1]), .load_value_bit2(p[2]), .load_value_bit3(p[3]),
      .count_bit0(q[1]), .count_bit1(q[2]), .count_bit2(q[3]), .count_bit3(q[4]),
      .carry_out_n(q[0]));
   pudc_next pudc_next_inst(.clk(clk), .reset_n(reset_n), .carry_in_n(q[0]), .hi_q(hi));
   task chk_hi(input [3:0] a, b);
   begin
      cmp_count = cmp_count + 1;
      errors = errors + (a !== b);
      if (a !== b)
         $display("[FAIL] upper stage exp %h got %h", a, b);
   end
   endtask
   task chk(input [4:0] a, b);
   begin
      cmp_count = cmp_count + 1;
      errors = errors + (a !== b);
      if (a !== b)
         $display("[FAIL] count exp %h got %h", a, b);
   end
   endtask
   task wrap_up;
   begin
      $display("cmp %0d err %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   initial
      forever #5 clk = ~clk;
   always @(negedge clk)
      if (x.size() > 0)
      begin
         n = x.pop_front();
         chk(n, q);
         chk_hi(hn, hi);
         if (!n[0])
            hn = hn + 4'h1;
      end
   initial
   begin
      r = $urandom(51487);
      repeat (8) @(posedge clk);
      reset_n <= 1;
      repeat (3000) @(posedge clk)
      begin
         m = cl ? 4'h0 : ld ? p : ci ? m : m + (up ? 4'h1 : 4'hf);
         r = $urandom;
         {cl, ld, up, ci, p} <= {&r[4:0], &r[9:5], r[10], &r[13:11], r[17:14]};
         e = &r[4:0] ? 4'h0 : &r[9:5] ? r[17:14] : m;
         x.push_back({e, &r[13:11] || e != {4{r[10]}}});
      end
      $display("random test done");
      wrap_up;
   end
endmodule
